/* rtl/sid_consts.svh */
// offsets, field constants and timing counts of the safety input diagnostics
// assumes: 40 MHz core clock, word-aligned register byte addresses
`ifndef SID_CONSTS_SVH
`define SID_CONSTS_SVH
`define SID_N_IN        8
`define SID_N_PAIR      4
`define SID_OFS_XS      8'h00
`define SID_OFS_MC      8'h04
`define SID_OFS_STATE   8'h08
`define SID_OFS_STAT    8'h0C
`define SID_OFS_MASK    8'h10
`define SID_LOW_EXEMPT  8'hF0
`define SID_SIG0        8'hC6
`define SID_SIG1        8'h6C
`define SID_SLOT_LAST   3'h7
`define SID_PERIOD_LAST 10'h3FF
`define SID_PHASE_LAST  10'h00F
`define SID_CLK_HZ      40000000
`define SID_TIMEOUT_MS  500
`define SID_TIMEOUT_CYC ((`SID_TIMEOUT_MS) * ((`SID_CLK_HZ) / 1000))
`endif

/* rtl/sid_pkg.sv */
// types shared by the safety input diagnostics
// assumes: constants come from sid_consts.svh
package sid_pkg;
  typedef enum logic [1:0] {
    PH_RUN    = 2'b00,
    PH_THR    = 2'b01,
    PH_LOW    = 2'b10,
    PH_SETTLE = 2'b11
  } phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] pulse_sel;
    logic [7:0] xs_en;
  } xs_cfg_t;

  typedef struct packed {
    logic [7:0] inv;
    logic [3:0] to_en;
    logic [3:0] pair_en;
  } mc_cfg_t;

  typedef struct packed {
    logic xcomp;
    logic tmo;
    logic xs;
    logic low;
    logic thr;
  } fault_t;
endpackage : sid_pkg

/* rtl/safety_input_diagnostics.sv */
// diagnostics for eight redundant safety inputs, paired into four sensors
// assumes: channel and test-feedback pins are asynchronous, one core clock
`timescale 1ns/100ps
`include "sid_consts.svh"

// Overview of operation
// R1: an input reads High only when both of its channels read High, otherwise Low.
// R2: the High threshold of every channel is tested cyclically and a failure raises the alarm.
// R3: the switch-to-Low ability is tested cyclically except on inputs 5 to 8, failure alarms.
// R4: two pulse outputs each carry their own signature and may feed sensor contacts.
// R5: an enabled input seen High while its assigned pulse is Low is a short and alarms.
// R6: adjacent contacts are fed from alternating pulses so cross-shorts show as mismatches.
// R7: cross-shorting test and time-out are enabled individually by configuration.
// R8: a multi-contact sensor is High only when every contact is in its active state.
// R9: with two normally closed contacts the sensor is High only when both are closed.
// R10: with NO and NC contacts the sensor is High only with NO actuated and NC not actuated.
// R11: with time-out on, contacts disagreeing longer than 0.5 s raise the alarm.
// R12: after power-on each input must be seen Low once before it is used.
// R13: the alarm holds until reset and forces all safety inputs Low.
module safety_input_diagnostics #(
  parameter int unsigned TIMEOUT_CYC = `SID_TIMEOUT_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire sid_pkg::bus_req_t bus,
  output      logic [31:0]      rdata,
  input  wire logic [7:0]       ch_a,
  input  wire logic [7:0]       ch_b,
  input  wire logic [7:0]       thr_ok_a,
  input  wire logic [7:0]       thr_ok_b,
  output      logic [1:0]       pulse,
  output      logic             thr_test,
  output      logic             low_test,
  output      logic [7:0]       safe_in,
  output      logic [3:0]       sensor,
  output      logic             alarm,
  output      logic             irq
);
  import sid_pkg::*;

  localparam logic [7:0]  SIG0    = `SID_SIG0;
  localparam logic [7:0]  SIG1    = `SID_SIG1;
  localparam logic [24:0] TO_LAST = 25'(TIMEOUT_CYC - 1);

  // synchroniser: only s2 is read by logic
  logic [31:0] s1;
  logic [31:0] s2;
  logic [7:0]  sa;
  logic [7:0]  sb;
  logic [7:0]  ta;
  logic [7:0]  tb;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 32'h00000000;
      s2 <= 32'h00000000;
    end else begin
      s1 <= {thr_ok_b, thr_ok_a, ch_b, ch_a};
      s2 <= s1;
    end
  end

  assign sa = s2[7:0];
  assign sb = s2[15:8];
  assign ta = s2[23:16];
  assign tb = s2[31:24];

  // test sequencer and pulse generator
  phase_t     phase;
  phase_t     next_phase;
  logic [9:0] tcnt;
  logic [9:0] next_tcnt;
  logic [2:0] slot;
  logic [2:0] next_slot;
  logic [2:0] bidx;
  logic [2:0] next_bidx;
  logic [1:0] next_pulse;
  logic       next_thr_test;
  logic       next_low_test;
  logic [1:0] fill; // the synchroniser holds reset zeros, not pins, for two edges
  logic [1:0] next_fill;

  always_comb begin
    next_phase = phase;
    next_tcnt  = tcnt + 10'h001;
    next_slot  = slot + 3'h1;
    next_bidx  = (slot == `SID_SLOT_LAST) ? bidx + 3'h1 : bidx;
    case (phase)
      PH_RUN: begin
        if (tcnt == `SID_PERIOD_LAST) begin
          next_phase = PH_THR; // R2
          next_tcnt  = 10'h000;
        end
      end
      PH_THR: begin
        if (tcnt == `SID_PHASE_LAST) begin
          next_phase = PH_LOW; // R3
          next_tcnt  = 10'h000;
        end
      end
      PH_LOW: begin
        if (tcnt == `SID_PHASE_LAST) begin
          next_phase = PH_SETTLE;
          next_tcnt  = 10'h000;
        end
      end
      default: begin
        // channels recover from the forced Low before evaluation resumes
        if (tcnt == `SID_PHASE_LAST) begin
          next_phase = PH_RUN;
          next_tcnt  = 10'h000;
        end
      end
    endcase
    next_pulse    = {SIG1[next_bidx], SIG0[next_bidx]}; // R4
    next_thr_test = (next_phase == PH_THR);
    next_low_test = (next_phase == PH_LOW);
    next_fill     = fill[1] ? fill : fill + 2'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase    <= PH_RUN;
      tcnt     <= 10'h000;
      slot     <= 3'h0;
      bidx     <= 3'h0;
      pulse    <= 2'h0;
      thr_test <= 1'b0;
      low_test <= 1'b0;
      fill     <= 2'h0;
    end else begin
      phase    <= next_phase;
      tcnt     <= next_tcnt;
      slot     <= next_slot;
      bidx     <= next_bidx;
      pulse    <= next_pulse;
      thr_test <= next_thr_test;
      low_test <= next_low_test;
      fill     <= next_fill;
    end
  end

  // configuration registers, written over the register port
  xs_cfg_t xs;
  mc_cfg_t mc;

  // input evaluation and fault detection
  fault_t      f;
  logic [7:0]  lvl;
  logic [7:0]  next_lvl;
  logic [7:0]  armed;
  logic [7:0]  next_armed;
  logic [7:0]  act;
  logic [7:0]  next_safe;
  logic [3:0]  next_sensor;
  logic        next_alarm;
  logic [24:0] to_cnt [4];
  logic [24:0] next_to_cnt [4];
  logic        run;
  logic        slot_end;

  always_comb begin
    f          = '0;
    next_lvl   = lvl;
    next_armed = armed;
    run        = (phase == PH_RUN);
    slot_end   = (slot == `SID_SLOT_LAST);
    if (phase == PH_THR && tcnt == `SID_PHASE_LAST) begin
      f.thr = ~&(ta & tb); // R2
    end
    if (phase == PH_LOW && tcnt == `SID_PHASE_LAST) begin
      f.low = |((sa | sb) & ~`SID_LOW_EXEMPT); // R3
    end
    for (int i = 0; i < `SID_N_IN; i++) begin
      if (run) begin
        if (xs.xs_en[i]) begin // R7
          // a pulse-fed input is only judged at the end of a slot
          if (slot_end) begin
            if (pulse[xs.pulse_sel[i]]) begin
              next_lvl[i] = sa[i] & sb[i]; // R1
              next_armed[i] = armed[i] | (fill[1] & ~next_lvl[i]); // R12
            end else if (sa[i] | sb[i]) begin
              f.xs = 1'b1; // R5 R6
            end
          end
        end else begin
          next_lvl[i] = sa[i] & sb[i]; // R1
          next_armed[i] = armed[i] | (fill[1] & ~next_lvl[i]); // R12
        end
        if (sa[i] != sb[i]) begin
          f.xcomp = 1'b1;
        end
      end
    end
    act = next_lvl ^ mc.inv;
    for (int p = 0; p < `SID_N_PAIR; p++) begin
      next_sensor[p] = mc.pair_en[p] & act[2*p] & act[2*p+1]
                     & next_armed[2*p] & next_armed[2*p+1]; // R8 R9 R10
      next_to_cnt[p] = to_cnt[p];
      if (run) begin
        if (mc.pair_en[p] && mc.to_en[p] && act[2*p] != act[2*p+1]) begin // R7
          if (to_cnt[p] == TO_LAST) begin
            f.tmo = 1'b1; // R11
          end else begin
            next_to_cnt[p] = to_cnt[p] + 25'h0000001;
          end
        end else begin
          next_to_cnt[p] = 25'h0000000;
        end
      end
    end
    next_alarm  = alarm | f.thr | f.low | f.xs | f.tmo; // R13
    next_safe   = next_lvl & next_armed & {8{~next_alarm}}; // R13
    next_sensor = next_sensor & {4{~next_alarm}};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl     <= 8'h00;
      armed   <= 8'h00;
      safe_in <= 8'h00;
      sensor  <= 4'h0;
      alarm   <= 1'b0;
      to_cnt  <= '{default: 25'h0000000};
    end else begin
      lvl     <= next_lvl;
      armed   <= next_armed;
      safe_in <= next_safe;
      sensor  <= next_sensor;
      alarm   <= next_alarm;
      to_cnt  <= next_to_cnt;
    end
  end

  // register port, interrupt status and mask
  xs_cfg_t     next_xs;
  mc_cfg_t     next_mc;
  logic [4:0]  stat;
  logic [4:0]  next_stat;
  logic [4:0]  mask;
  logic [4:0]  next_mask;
  logic [4:0]  clr;
  logic [31:0] next_rdata;
  logic        next_irq;

  always_comb begin
    next_xs    = xs;
    next_mc    = mc;
    next_mask  = mask;
    clr        = 5'h00;
    next_rdata = 32'h00000000;
    if (bus.wr) begin
      if (bus.addr == `SID_OFS_XS) begin
        next_xs = bus.wdata[15:0];
      end else if (bus.addr == `SID_OFS_MC) begin
        next_mc = bus.wdata[15:0];
      end else if (bus.addr == `SID_OFS_STAT) begin
        clr = bus.wdata[4:0];
      end else if (bus.addr == `SID_OFS_MASK) begin
        next_mask = bus.wdata[4:0];
      end
    end
    // a fault in the clearing cycle stays set
    next_stat = (stat & ~clr) | f;
    if (bus.rd) begin
      if (bus.addr == `SID_OFS_XS) begin
        next_rdata = {16'h0000, xs};
      end else if (bus.addr == `SID_OFS_MC) begin
        next_rdata = {16'h0000, mc};
      end else if (bus.addr == `SID_OFS_STATE) begin
        next_rdata = {7'h00, alarm, armed, 4'h0, sensor, safe_in};
      end else if (bus.addr == `SID_OFS_STAT) begin
        next_rdata = {27'h0000000, stat};
      end else if (bus.addr == `SID_OFS_MASK) begin
        next_rdata = {27'h0000000, mask};
      end
    end
    next_irq = |(next_stat & next_mask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xs    <= '0;
      mc    <= '0;
      stat  <= 5'h00;
      mask  <= 5'h00;
      rdata <= 32'h00000000;
      irq   <= 1'b0;
    end else begin
      xs    <= next_xs;
      mc    <= next_mc;
      stat  <= next_stat;
      mask  <= next_mask;
      rdata <= next_rdata;
      irq   <= next_irq;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_xcomp_forces_low: assert property ( // R1
    (run && !xs.xs_en[0] && sa[0] != sb[0]) |=> !safe_in[0])
    else $error("channel mismatch did not force input low");
  a_thr_fail_alarm: assert property ( // R2
    (phase == PH_THR && tcnt == `SID_PHASE_LAST && !(&(ta & tb))) |=> alarm)
    else $error("threshold test failure did not raise alarm");
  a_low_fail_alarm: assert property ( // R3
    (phase == PH_LOW && tcnt == `SID_PHASE_LAST && (sa[0] | sb[0])) |=> alarm)
    else $error("low switchability failure did not raise alarm");
  a_low_test_len: assert property ($rose(low_test) |-> low_test [*8]) // R3
    else $error("low test phase too short");
  a_pulse_slot_edge: assert property ($changed(pulse) |-> slot == 3'h0) // R4
    else $error("pulse changed inside a slot");
  a_xs_short_alarm: assert property ( // R5
    (run && slot_end && xs.xs_en[4] && !pulse[xs.pulse_sel[4]] && (sa[4] | sb[4]))
    |=> alarm && stat[2])
    else $error("foreign signature not flagged");
  // mc may be rewritten at the edge that registers sensor, so its old copy applies
  a_sensor_and: assert property ( // R8
    sensor[1] |-> $past(mc.pair_en[1]) && (lvl[2] ^ $past(mc.inv[2]))
    && (lvl[3] ^ $past(mc.inv[3])))
    else $error("sensor high without all contacts active");
  a_timeout_alarm: assert property ( // R11
    (run && mc.pair_en[0] && mc.to_en[0] && to_cnt[0] == TO_LAST
     && act[0] != act[1]) |=> alarm)
    else $error("time-out expiry did not raise alarm");
  a_arm_before_use: assert property (safe_in[2] |-> armed[2]) // R12
    else $error("input used before first low");
  a_alarm_sticky: assert property (alarm |=> alarm && safe_in == 8'h00 && sensor == 4'h0) // R13
    else $error("alarm dropped or inputs not forced low");
  a_irq_level: assert property (irq |-> $past(|(next_stat & next_mask)))
    else $error("irq without unmasked status");
  c_thr_test:  cover property ($fell(thr_test) ##1 low_test);
  c_xs_fault:  cover property (f.xs ##1 alarm);
  c_sensor_on: cover property ($rose(sensor[1]));
  c_stat_clr:  cover property (bus.wr && bus.addr == `SID_OFS_STAT ##1 stat == 5'h00);
endmodule : safety_input_diagnostics

/* test/sensor_field.sv */
// external switches and contacts wired to the eight safety inputs
// assumes: the bench drives contact states and injected faults
`timescale 1ns/100ps
module sensor_field (
  input  wire logic [1:0] pulse,
  input  wire logic       low_test,
  input  wire logic [7:0] closed,
  input  wire logic [7:0] feed,
  input  wire logic [7:0] sel,
  input  wire logic [7:0] short_hi,
  input  wire logic [7:0] split_b,
  input  wire logic [7:0] stuck,
  input  wire logic [7:0] thr_flt,
  output      logic [7:0] ch_a,
  output      logic [7:0] ch_b,
  output      logic [7:0] thr_ok_a,
  output      logic [7:0] thr_ok_b
);
  logic [7:0] live;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // a fed contact only passes its own pulse, so neighbours differ
      live[i] = short_hi[i] | (closed[i] & (~feed[i] | pulse[sel[i]]));
    end
    // the low test pulls healthy channels down; a stuck channel ignores it
    ch_a     = stuck | (live & {8{~low_test}});
    ch_b     = stuck | (live & ~split_b & {8{~low_test}});
    thr_ok_a = ~thr_flt;
    thr_ok_b = 8'hFF;
  end
endmodule : sensor_field

/* test/safety_input_diagnostics_tb_top.sv */
// self-checking bench of the safety input diagnostics
// assumes: sensor_field models the wiring; timeout shortened to TMO cycles
`timescale 1ns/100ps
module safety_input_diagnostics_tb_top;
  import sid_pkg::*;
  localparam int TMO = 50;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  bus_req_t    bus      = '0;
  logic [31:0] rdata, rv;
  logic [7:0]  ch_a, ch_b, thr_ok_a, thr_ok_b, safe_in, v, inv;
  logic [7:0]  closed = '0, feed = '0, sel = '0, short_hi = '0;
  logic [7:0]  split_b = '0, stuck = '0, thr_flt = '0;
  logic [1:0]  pulse;
  logic [3:0]  sensor;
  logic        thr_test, low_test, alarm, irq;
  int          bad_count = 0, comparisons = 0, seed = 32'h18ea;

  always #12.5 core_clk = ~core_clk;

  safety_input_diagnostics #(.TIMEOUT_CYC(TMO)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .bus(bus), .rdata(rdata), .ch_a(ch_a), .ch_b(ch_b), .thr_ok_a(thr_ok_a),
    .thr_ok_b(thr_ok_b), .pulse(pulse), .thr_test(thr_test), .low_test(low_test),
    .safe_in(safe_in), .sensor(sensor), .alarm(alarm), .irq(irq));
  sensor_field fld (.pulse(pulse), .low_test(low_test), .closed(closed), .feed(feed),
    .sel(sel), .short_hi(short_hi), .split_b(split_b), .stuck(stuck), .thr_flt(thr_flt),
    .ch_a(ch_a), .ch_b(ch_b), .thr_ok_a(thr_ok_a), .thr_ok_b(thr_ok_b));

  function logic [3:0] exp_sensor(input logic [7:0] c, input logic [3:0] en,
                                  input logic [7:0] iv);
    logic [7:0] act;
    act = c ^ iv;
    for (int p = 0; p < 4; p++) begin
      exp_sensor[p] = en[p] & act[2*p] & act[2*p+1];
    end
  endfunction : exp_sensor

  task close_out;
    $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t register read %h, expected %h", $time, got, exp);
    end
  endtask : chk32

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t pin value %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1 rv = rdata;
    chk32(rv, exp);
  endtask : rchk

  // 0 safe_in, 1 sensor, 2 alarm; test phases freeze inputs for 48 cycles
  task wait_for(input int k, input logic [7:0] exp);
    logic [7:0] g;
    for (int n = 0; n < 1500; n++) begin
      @(posedge core_clk);
      #1 g = (k == 0) ? safe_in : (k == 1) ? {4'h0, sensor} : {7'h0, alarm};
      if (g === exp) break;
    end
    chk8(g, exp);
    if (g !== exp) close_out();
  endtask : wait_for

  // st holds channels stuck high through reset, so they are never seen Low
  task do_reset(input logic [7:0] st);
    @(posedge core_clk);
    rst_n <= 1'b0;
    {closed, feed, sel, short_hi, split_b, thr_flt} <= '0;
    stuck <= st;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : do_reset

  initial begin
    do_reset(8'h00);
    rchk(8'h10, 32'h0);
    rchk(8'h0C, 32'h0);
    wr(8'h10, 32'h1F);
    rchk(8'h10, 32'h1F);
    wr(8'h14, 32'hFFFF_FFFF);
    rchk(8'h14, 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      @(posedge core_clk);
      closed <= v;
      wait_for(0, v);
    end
    chk8({7'h0, alarm}, 8'h0);
    @(posedge core_clk);
    closed  <= 8'hFF;
    split_b <= 8'h01;
    wait_for(0, 8'hFE);
    rchk(8'h0C, 32'h10);
    chk8({7'h0, irq}, 8'h1);
    @(posedge core_clk);
    split_b <= 8'h00;
    wait_for(0, 8'hFF);
    rchk(8'h08, 32'h00FF_00FF);
    wr(8'h0C, 32'h10);
    rchk(8'h0C, 32'h0);
    chk8({7'h0, irq}, 8'h0);
    for (int j = 0; j < 8; j++) begin
      v   = {4'h0, 2'(j), 2'b00};
      inv = j[2] ? 8'h08 : 8'h00;
      if (j[1:0] == 2'b00) wr(8'h04, {16'h0, inv, 8'h02});
      @(posedge core_clk);
      closed <= v;
      wait_for(1, {4'h0, exp_sensor(v, 4'h2, inv)});
    end
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0000_2030);
    @(posedge core_clk);
    {feed, sel, closed} <= {8'h30, 8'h20, 8'h30};
    // one whole test period of 1072 cycles with correct signatures
    repeat (1100) @(posedge core_clk);
    chk8({7'h0, alarm}, 8'h0);
    chk8(safe_in, 8'h30);
    @(posedge core_clk);
    sel <= 8'h30;
    wait_for(2, 8'h1);
    rchk(8'h0C, 32'h4);
    chk8(safe_in, 8'h00);
    chk8({7'h0, irq}, 8'h1);
    do_reset(8'h00);
    wr(8'h04, 32'h11);
    @(posedge core_clk);
    closed <= 8'h01;
    repeat (TMO - 10) @(posedge core_clk);
    chk8({7'h0, alarm}, 8'h0);
    wait_for(2, 8'h1);
    rchk(8'h0C, 32'h8);
    do_reset(8'h00);
    thr_flt <= 8'h01;
    wait_for(2, 8'h1);
    chk8({6'h00, thr_test, low_test}, 8'h01);
    rchk(8'h0C, 32'h1);
    do_reset(8'h20);
    repeat (1100) @(posedge core_clk);
    chk8({7'h0, alarm}, 8'h0);
    chk8(safe_in, 8'h00);
    @(posedge core_clk);
    stuck <= 8'h21;
    wait_for(2, 8'h1);
    rchk(8'h0C, 32'h2);
    close_out();
  end
endmodule : safety_input_diagnostics_tb_top
